// file: hdl/ncl_pkg.sv
`default_nettype none
package ncl_pkg;
    // register byte addresses on the wishbone slave (word aligned)
    localparam logic [7:0]  ADDR_STATUS   = 8'h00;
    localparam logic [7:0]  ADDR_INDEX    = 8'h04;
    localparam logic [7:0]  ADDR_RSVD     = 8'h08;
    localparam logic [7:0]  ADDR_CCOB     = 8'h0C;
    localparam logic [7:0]  ADDR_SECURITY = 8'h10;
    // status register field positions
    localparam int          ST_COMMAND_COMPLETE_FLAG_BIT   = 7;
    localparam int          ST_ACCESS_ERROR_FLAG_BIT = 5;
    localparam int          ST_MG1_BIT    = 1;
    localparam int          ST_MG0_BIT    = 0;
    // command codes
    localparam logic [7:0]  CMD_VERIFY_ALL = 8'h01;
    localparam logic [7:0]  CMD_VERIFY_BLK = 8'h02;
    // block selection codes
    localparam logic [1:0]  BLK_EEPROM = 2'h0;
    localparam logic [1:0]  BLK_PFLASH = 2'h3;
    // security field value that means unsecured
    localparam logic [1:0]  SEC_UNSECURED = 2'h2;
    localparam logic [1:0]  SEC_RESET     = 2'h1;
    // command object geometry
    localparam int          CCOB_WORDS = 6;
    localparam logic [2:0]  IDX_RESET  = 3'h0;
    // verify scan sizes in words (plain defaults)
    localparam logic [15:0] EE_WORDS = 16'h0400;
    localparam logic [15:0] PF_WORDS = 16'h8000;
    typedef enum logic [1:0] {NCL_IDLE, NCL_SCAN, NCL_DONE} ncl_state_t;
endpackage
`default_nettype wire

// file: hdl/ncl_sequencer.sv
// Summary of operation
// RULE1: accepted commands depend on operating mode and security state.
// RULE2: security input high selects secured, low selects unsecured.
// RULE3: verify-all is 0x01, verify-block 0x02; both accepted in all states.
// RULE4: block code 00 eeprom, 11 program flash, 01/10 raise access error.
// RULE5: verify-block with index not 000 at launch raises access error.
// RULE6: verify-block checks the whole block, then sets completion flag.
// RULE7: a block found not erased sets both verify status bits.
// RULE8: upper status on any read error, lower only on uncorrectable ones.
// RULE9: security field 10 means unsecured; every other value secured.
// RULE10: index register keeps only index bits; others read zero.
// RULE11: reserved test register reads zero and ignores writes.
// RULE12: command object is six 16-bit words, byte access supported.
// RULE13: writing one to completion flag launches and clears it.
// RULE14: parameters locked from launch until completion flag returns.
// RULE15: returned values are readable only once the flag is set.
// RULE16: index positions 110 and 111 ignore writes and read 0x0000.
// RULE17: word 0 holds code and address 17:16, word 1 address 15:0.
// RULE18: a new command is only accepted after the current one ends.
// RULE19: software programs only erased words and never reprograms bits.
// RULE20: array byte and aligned word reads complete in one cycle.
// RULE21: erased bits read as one, programmed bits read as zero.
// RULE22: on access error the command is skipped and the flag set at once.
// RULE23: byte access reaches high or low byte of the selected word.
`default_nettype none
module ncl_sequencer
    import ncl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // device state straps (asynchronous pins)
    input  wire logic        special_mode_input,
    input  wire logic        secure_input,
    // flash array read port
    output logic      [15:0] array_addr,
    output logic             array_sel_pflash,
    output logic             array_rd,
    input  wire logic [15:0] array_rdata,
    input  wire logic        array_err_corr,
    input  wire logic        array_err_uncorr,
    // status out
    output logic             command_complete_flag,
    output logic             launch_pulse
);
    // synchronisers for mode and security pins; the straps may move at
    // any time, so only the second stage is read by the logic below, and
    // a change takes two clocks to reach the security register read data
    logic [1:0] mode_sync_q;
    logic [1:0] sec_sync_q;
    logic       special_mode;
    logic       secured;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_sync_q <= 2'h0;
            sec_sync_q  <= 2'h0;
        end else begin
            mode_sync_q <= {mode_sync_q[0], special_mode_input};
            sec_sync_q  <= {sec_sync_q[0], secure_input};
        end
    end
    assign special_mode = mode_sync_q[1]; // RULE1
    assign secured      = sec_sync_q[1];  // RULE2

    // registers
    logic [2:0]  index_q;
    logic [15:0] ccob_q [CCOB_WORDS];
    logic [1:0]  sec_field_q;
    logic        command_complete_flag_q;
    logic        access_error_flag_q;
    logic        mg1_q;
    logic        mg0_q;
    ncl_state_t  state_q;
    logic [15:0] scan_cnt_q;
    logic [15:0] scan_len_q;
    logic        scan_pf_q;
    logic        rd_pend_q;
    logic        wb_ack_q;
    logic        wb_err_q;
    logic [31:0] wb_dat_q;
    logic        launch_q;

    // bus decode
    logic        req;
    logic        wr;
    logic        hit_status;
    logic        hit_index;
    logic        hit_rsvd;
    logic        hit_ccob;
    logic        hit_sec;
    logic        mapped;
    assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_q & ~wb_err_q;
    assign wr         = req & wb_we_i;
    assign hit_status = wb_adr_i == ADDR_STATUS;
    assign hit_index  = wb_adr_i == ADDR_INDEX;
    assign hit_rsvd   = wb_adr_i == ADDR_RSVD;
    assign hit_ccob   = wb_adr_i == ADDR_CCOB;
    assign hit_sec    = wb_adr_i == ADDR_SECURITY;
    assign mapped = hit_status | hit_index | hit_rsvd | hit_ccob | hit_sec;

    // security: only the unsecured code with the pin low frees the part;
    // the pin can add protection but never remove it, so a stray field
    // write cannot open a part that is strapped secure
    logic sec_state;
    assign sec_state = secured | (sec_field_q != SEC_UNSECURED); // RULE9

    // launch: a one written to the completion flag while idle
    logic launch;
    assign launch = wr & hit_status & wb_sel_i[0]
                  & wb_dat_i[ST_COMMAND_COMPLETE_FLAG_BIT] & command_complete_flag_q; // RULE13 RULE18

    // launch checks on the command word
    logic [7:0] cmd_code;
    logic [1:0] blk_code;
    logic       cmd_known;
    logic       blk_bad;
    logic       idx_bad;
    logic       launch_err;
    assign cmd_code  = ccob_q[0][15:8];                  // RULE17
    assign blk_code  = ccob_q[0][1:0];                   // RULE17
    // both verify commands are legal in every mode/security combination
    assign cmd_known = (cmd_code == CMD_VERIFY_ALL)
                     | (cmd_code == CMD_VERIFY_BLK);     // RULE3 RULE1
    assign blk_bad   = (cmd_code == CMD_VERIFY_BLK)
                     & (blk_code != BLK_EEPROM)
                     & (blk_code != BLK_PFLASH);         // RULE4
    assign idx_bad   = (cmd_code == CMD_VERIFY_BLK)
                     & (index_q != IDX_RESET);           // RULE5
    assign launch_err = ~cmd_known | blk_bad | idx_bad;

    // write access to the command object: locked while a command runs
    logic idx_valid;
    logic ccob_wr;
    assign idx_valid = index_q < 3'(CCOB_WORDS);                // RULE16
    assign ccob_wr   = wr & hit_ccob & command_complete_flag_q & idx_valid;      // RULE14

    // read mux; command object hidden while running, because a command
    // may hand back results there and half-written words must not leak;
    // unused status bits read as zero
    logic [15:0] ccob_rd;
    logic [31:0] rd_data;
    assign ccob_rd = (idx_valid & command_complete_flag_q) ? ccob_q[index_q]
                                          : 16'h0000; // RULE15 RULE16
    assign rd_data =
        hit_status ? {24'h000000, command_complete_flag_q, 1'b0, access_error_flag_q, 3'h0,
                      mg1_q, mg0_q} :
        hit_index  ? {29'h00000000, index_q} :               // RULE10
        hit_ccob   ? {16'h0000, ccob_rd} :                   // RULE12
        hit_sec    ? {28'h0000000, special_mode, sec_state,
                      sec_field_q} :
                     32'h00000000;                           // RULE11

    // bus answer: one wait-free ack cycle, error on unmapped addresses;
    // the error answer keeps a stray address from hanging the master,
    // and read data is zero on writes so the bus never shows stale words
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_q <= 1'b0;
            wb_err_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            wb_ack_q <= req & mapped;
            wb_err_q <= req & ~mapped;
            wb_dat_q <= (req & ~wb_we_i) ? rd_data : 32'h00000000;
        end
    end

    // index and security field writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            index_q     <= IDX_RESET;
            sec_field_q <= SEC_RESET;
        end else begin
            if (wr & hit_index & wb_sel_i[0])
                index_q <= wb_dat_i[2:0];                    // RULE10
            if (wr & hit_sec & wb_sel_i[0])
                sec_field_q <= wb_dat_i[1:0];
        end
    end

    // command object words, byte lanes map to high and low byte;
    // lanes 2 and 3 have no storage, so the upper half always reads zero,
    // and index 6 and 7 have no word here, so writes there vanish
    generate
        for (genvar i = 0; i < CCOB_WORDS; i++) begin : g_ccob
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ccob_q[i] <= 16'h0000;
                end else if (ccob_wr && index_q == 3'(i)) begin
                    if (wb_sel_i[0])
                        ccob_q[i][7:0] <= wb_dat_i[7:0];     // RULE23
                    if (wb_sel_i[1])
                        ccob_q[i][15:8] <= wb_dat_i[15:8];   // RULE23 RULE12
                end
            end
        end
    endgenerate

    // verify scan: every word must read all ones to count as erased;
    // scan_last marks the cycle that checks the final word of the block,
    // and a word is judged only in the cycle after its read was issued
    logic scan_last;
    logic not_erased;
    assign scan_last  = rd_pend_q & (scan_cnt_q == scan_len_q);
    assign not_erased = rd_pend_q & (array_rdata != 16'hFFFF); // RULE21

    // sequencer event decode; the registers below each keep to one concern
    // so that a flag's set and clear priority can be read at a glance
    logic        in_idle;
    logic        in_scan;
    logic        in_done;
    logic        launch_ok;
    logic        acc_set;
    logic        acc_clr;
    logic        scan_ee;
    logic [15:0] scan_len_d;
    logic        cnt_step;
    logic        rd_any_err;
    logic        rd_bad_err;
    logic        blank_fail;
    logic        mg1_set;
    logic        mg0_set;
    assign in_idle    = state_q == NCL_IDLE;
    assign in_scan    = state_q == NCL_SCAN;
    assign in_done    = state_q == NCL_DONE;
    assign launch_ok  = launch & ~launch_err;                // RULE18
    assign acc_set    = launch & launch_err;                 // RULE4 RULE5
    // write one clears the error flag, honoured only while idle
    assign acc_clr    = in_idle & wr & hit_status & wb_sel_i[0]
                      & wb_dat_i[ST_ACCESS_ERROR_FLAG_BIT];
    // verify-all and block code 11 both walk the program flash range
    assign scan_ee    = (cmd_code == CMD_VERIFY_BLK)
                      & (blk_code == BLK_EEPROM);
    assign scan_len_d = scan_ee ? EE_WORDS - 16'h0001
                                : PF_WORDS - 16'h0001;
    assign cnt_step   = in_scan & rd_pend_q & ~scan_last;
    // a word's error flags are only trusted in the cycle its data returns
    assign rd_any_err = in_scan & rd_pend_q
                      & (array_err_corr | array_err_uncorr); // RULE8
    assign rd_bad_err = in_scan & rd_pend_q & array_err_uncorr; // RULE8
    assign blank_fail = in_scan & not_erased;                // RULE7
    assign mg1_set    = rd_any_err | blank_fail;             // RULE7 RULE8
    assign mg0_set    = rd_bad_err | blank_fail;             // RULE7 RULE8

    // state register: idle, scan, then one cycle that raises the flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= NCL_IDLE;
        end else begin
            case (state_q)
                NCL_IDLE: begin
                    if (acc_set)
                        state_q <= NCL_DONE;                 // RULE22
                    else if (launch_ok)
                        state_q <= NCL_SCAN;                 // RULE6
                end
                NCL_SCAN: begin
                    if (scan_last)
                        state_q <= NCL_DONE;
                end
                NCL_DONE: state_q <= NCL_IDLE;
                default:  state_q <= NCL_IDLE;
            endcase
        end
    end

    // completion flag: the launch write clears it, the done state sets it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            command_complete_flag_q <= 1'b1;
        end else if (launch) begin
            command_complete_flag_q <= 1'b0;                                  // RULE13
        end else if (in_done) begin
            command_complete_flag_q <= 1'b1;                                  // RULE6 RULE22
        end
    end

    // access error: a failed launch outranks a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            access_error_flag_q <= 1'b0;
        end else if (acc_set) begin
            access_error_flag_q <= 1'b1;                                // RULE4 RULE5
        end else if (acc_clr) begin
            access_error_flag_q <= 1'b0;
        end
    end

    // verify status: cleared at every launch, sticky through the scan
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mg1_q <= 1'b0;
            mg0_q <= 1'b0;
        end else if (launch) begin
            mg1_q <= 1'b0;
            mg0_q <= 1'b0;
        end else begin
            if (mg1_set)
                mg1_q <= 1'b1;                               // RULE7 RULE8
            if (mg0_set)
                mg0_q <= 1'b1;                               // RULE7 RULE8
        end
    end

    // scan parameters are latched at launch so that later writes to the
    // command object cannot change a scan under way
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scan_pf_q  <= 1'b0;
            scan_len_q <= 16'h0000;
        end else if (launch_ok) begin
            scan_pf_q  <= ~scan_ee;
            scan_len_q <= scan_len_d;                        // RULE6
        end
    end

    // word counter and read-pending marker; one word is checked per cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scan_cnt_q <= 16'h0000;
            rd_pend_q  <= 1'b0;
        end else begin
            rd_pend_q <= in_scan & ~scan_last;
            if (launch_ok)
                scan_cnt_q <= 16'h0000;
            else if (cnt_step)
                scan_cnt_q <= scan_cnt_q + 16'h0001;
        end
    end

    // launch pulse for the outside world, one cycle after the write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            launch_q <= 1'b0;
        end else begin
            launch_q <= launch;
        end
    end

    // array read port, registered from the scan counter; the address runs
    // one word ahead because the data is checked in the following cycle
    logic [15:0] array_addr_d;
    logic        array_rd_d;
    assign array_addr_d = rd_pend_q ? scan_cnt_q + 16'h0001
                                    : 16'h0000;              // RULE20
    assign array_rd_d   = in_scan & ~scan_last;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            array_addr       <= 16'h0000;
            array_sel_pflash <= 1'b0;
            array_rd         <= 1'b0;
        end else begin
            array_addr       <= array_addr_d;
            array_sel_pflash <= scan_pf_q;
            array_rd         <= array_rd_d;
        end
    end

    // outputs come straight from their registers
    assign wb_ack_o              = wb_ack_q;
    assign wb_err_o              = wb_err_q;
    assign wb_dat_o              = wb_dat_q;
    assign command_complete_flag = command_complete_flag_q;
    assign launch_pulse          = launch_q;
endmodule
`default_nettype wire

// file: tb/ncl_sequencer_sva.sv
`default_nettype none
module ncl_sequencer_sva
    import ncl_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // scan side and status
    input wire logic [15:0] array_addr,
    input wire logic        array_sel_pflash,
    input wire logic        array_rd,
    input wire logic        command_complete_flag,
    input wire logic        launch_pulse
);
    logic zero_rd_q;
    // a request counts only while no answer is pending
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire launch = take && wb_we_i && wb_adr_i == ADDR_STATUS
        && wb_sel_i[0] && wb_dat_i[ST_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag;
    wire mapped = wb_adr_i inside {ADDR_STATUS, ADDR_INDEX, ADDR_RSVD,
        ADDR_CCOB, ADDR_SECURITY};
    // reads that must come back empty, held until their ack
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            zero_rd_q <= 1'b0;
        else
            zero_rd_q <= take && !wb_we_i && (wb_adr_i == ADDR_RSVD
                || (wb_adr_i == ADDR_CCOB && !command_complete_flag));
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_answer_next: assert property (take |=> wb_ack_o || wb_err_o)
        else $error("request not answered");
    a_answer_once: assert property (
        wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("answer held too long");
    a_err_unmapped: assert property (
        take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_launch_pulse: assert property (launch |-> ##[1:2] launch_pulse)
        else $error("launch not seen");
    a_flag_clears: assert property (
        launch |-> ##[1:2] !command_complete_flag)
        else $error("flag not cleared");
    a_pulse_once: assert property (launch_pulse |=> !launch_pulse)
        else $error("launch pulse too long");
    a_scan_busy: assert property (
        array_rd |-> !command_complete_flag)
        else $error("flag set during scan");
    a_ee_range: assert property (
        array_rd && !array_sel_pflash |-> array_addr < EE_WORDS)
        else $error("scan outside block");
    a_zero_reads: assert property (
        wb_ack_o && zero_rd_q |-> wb_dat_o == 32'h0)
        else $error("hidden data returned");
    c_launch: cover property (launch);
    c_done: cover property ($rose(command_complete_flag));
    c_refused: cover property (wb_err_o);
endmodule
bind ncl_sequencer ncl_sequencer_sva u_sva (
    .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .array_addr(array_addr),
    .array_sel_pflash(array_sel_pflash), .array_rd(array_rd),
    .command_complete_flag(command_complete_flag),
    .launch_pulse(launch_pulse));
`default_nettype wire

// file: tb/ncl_sequencer_tb.sv
`default_nettype none
module ncl_sequencer_tb
    import ncl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, nrst, cyc, stb, we, smode, sec_in, ecorr, euncorr;
    logic        ack, err, flag, got_err;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [15:0] fill, v;
    logic [31:0] wdat, rdat, rd;
    int          error_cnt = 0;
    int          comparisons = 0;
    // word0, launch index, dirty fill, corr err, uncorr err, expected status
    logic [31:0] cases [8] = '{32'h0200_0000, 32'h0200_0103, 32'h0200_0023,
        32'h0201_0004, 32'h0202_0004, 32'h0200_1004, 32'h0203_0042,
        32'h0100_0103};

    ncl_sequencer uut (
        .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .special_mode_input(smode), .secure_input(sec_in),
        .array_addr(), .array_sel_pflash(), .array_rd(),
        .array_rdata(fill), .array_err_corr(ecorr),
        .array_err_uncorr(euncorr), .command_complete_flag(flag),
        .launch_pulse());

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard: scans total well under this span
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    function automatic logic [31:0] stat(input logic [2:0] e);
        return {24'h0, 2'h2, e[2], 3'h0, e[1:0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one classic cycle; the request stands until the rising edge that
    // samples ack, data is taken and the request dropped at that edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, d};
        do @(posedge clk); while (!(ack || err));
        rd = rdat;
        got_err = err;
        {cyc, stb} <= 2'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, 4'hF, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 4'hF, 32'h0);
    endtask

    // load, launch, poke while locked, then check the outcome
    task automatic run(input logic [31:0] c);
        fill <= c[8] ? 16'($urandom) & 16'h7FFF : 16'hFFFF;
        {ecorr, euncorr} <= c[6:5];
        wr(ADDR_INDEX, 32'h0);
        bus(1'b1, ADDR_CCOB, 4'h3, {16'h0, c[31:16]});
        wr(ADDR_INDEX, {28'h0, c[15:12]});
        wr(ADDR_STATUS, 32'h80);
        repeat (4) @(negedge clk);
        check({31'h0, flag}, {31'h0, c[2]});
        if (!c[2] && c[15:12] == 4'h0) begin
            bus(1'b1, ADDR_CCOB, 4'h3, 32'hABCD);
            rdr(ADDR_CCOB);
            check(rd, 32'h0);
        end
        while (!flag) @(negedge clk);
        rdr(ADDR_STATUS);
        check(rd & 32'hA3, stat(c[2:0]));
        rdr(ADDR_CCOB);
        if (c[15:12] == 4'h0)
            check(rd & 32'hFFFF, {16'h0, c[31:16]});
        wr(ADDR_STATUS, 32'h20);
    endtask

    initial begin
        {cyc, stb, we, smode, sec_in, ecorr, euncorr, nrst} = 8'h0;
        {adr, sel, wdat, fill} = {8'h0, 4'h0, 32'h0, 16'hFFFF};
        void'($urandom(42));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdr(ADDR_STATUS);
        check(rd & 32'hA3, stat(3'h0));
        rdr(ADDR_SECURITY);
        check(rd & 32'hF, 32'h5);
        wr(ADDR_RSVD, $urandom);
        rdr(ADDR_RSVD);
        check(rd, 32'h0);
        bus(1'b0, 8'h14, 4'hF, 32'h0);
        check({31'h0, got_err}, 32'h1);
        repeat (4) begin
            v = 16'($urandom);
            wr(ADDR_INDEX, {16'h0, v});
            rdr(ADDR_INDEX);
            check(rd, {29'h0, v[2:0]});
        end
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            wr(ADDR_INDEX, 32'(i));
            bus(1'b1, ADDR_CCOB, 4'h3, {16'h0, v});
            bus(1'b1, ADDR_CCOB, 4'h1, {24'h0, ~v[7:0]});
            rdr(ADDR_CCOB);
            v = i < 6 ? {v[15:8], ~v[7:0]} : 16'h0;
            check(rd & 32'hFFFF, {16'h0, v});
        end
        $display("test registers done");
        wr(ADDR_SECURITY, 32'h2);
        foreach (cases[k])
            run(cases[k]);
        $display("test commands done");
        for (int m = 0; m < 4; m++) begin
            {smode, sec_in} <= 2'(m);
            run(32'h0200_0000);
            rdr(ADDR_SECURITY);
            check(rd & 32'hF, {28'h0, m[1], m[0], 2'h2});
        end
        $display("test modes done");
        end_of_test();
    end
endmodule
`default_nettype wire
